// *** nbu_uart_regs.svh ***
`ifndef NBU_UART_REGS_SVH
`define NBU_UART_REGS_SVH
`define NBU_ADDR_W 8
`define NBU_CTRL_OFS 8'h98
`define NBU_BUF_OFS 8'h9C
`define NBU_CFG_OFS 8'hA0
`define NBU_CFG_RST 4'h0
`define NBU_B_TOP 7
`define NBU_B_MLO 6
`define NBU_B_MP 5
`define NBU_B_REN 4
`define NBU_B_TB8 3
`define NBU_B_RB8 2
`define NBU_B_TI 1
`define NBU_B_RI 0
`define NBU_C_FSEL 0
`define NBU_C_BDBL 1
`define NBU_C_TXT2 2
`define NBU_C_RXT2 3
`define NBU_DIV_LAST 4'hF
`define NBU_DIV_HALF 3
`define NBU_SMP_A 4'h7
`define NBU_SMP_B 4'h8
`define NBU_SMP_C 4'h9
`define NBU_RX_ONES 10'h3FF
`define NBU_LAST_9B 4'hA
`define NBU_LAST_8B 4'h9
`define NBU_LAST_SH 4'h8
`endif

// *** nbu_pkg.sv ***
package nbu_pkg;
  typedef enum logic [1:0] {
    NBU_SHIFT = 2'b00,
    NBU_UART8 = 2'b01,
    NBU_UART9F = 2'b10,
    NBU_UART9V = 2'b11
  } nbu_mode_t;
  typedef enum logic [1:0] {
    NBU_RX_IDLE = 2'b00,
    NBU_RX_DATA = 2'b01,
    NBU_RX_STOP = 2'b10
  } nbu_rx_state_t;
endpackage : nbu_pkg

// *** nbu_port_if.sv ***
`timescale 1ns/100ps
interface nbu_port_if;
  import nbu_pkg::*;
  nbu_mode_t mode;
  logic tx_tick;
  logic rx_tick;
  logic tx_load;
  logic [8:0] tx_word;
  logic rx_enable;
  logic mp;
  logic rx_flag;
  logic rx_line;
  logic txd;
  logic sclk;
  logic tx_busy;
  logic tx_pend;
  logic tx_roll;
  logic tx_done_set;
  logic rx_load;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic fe_set;
  modport core (
    output mode, tx_tick, rx_tick, tx_load, tx_word, rx_enable, mp, rx_flag, rx_line,
    input txd, sclk, tx_busy, tx_pend, tx_roll, tx_done_set, rx_load, rx_data, rx_ninth,
    fe_set
  );
  modport tx (
    input mode, tx_tick, tx_load, tx_word, mp,
    output txd, sclk, tx_busy, tx_pend, tx_roll, tx_done_set
  );
  modport rx (
    input mode, rx_tick, rx_enable, mp, rx_flag, rx_line,
    output rx_load, rx_data, rx_ninth, fe_set
  );
endinterface : nbu_port_if

// *** nbu_uart_tx.sv ***
`timescale 1ns/100ps
`include "nbu_uart_regs.svh"
module nbu_uart_tx
  import nbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  nbu_port_if.tx port
);
  logic [3:0] div_reg;
  logic [10:0] frame_reg;
  logic [3:0] cnt_reg;
  logic [3:0] last_idx;
  logic pend_reg;
  logic busy_reg;
  logic txd_reg;
  logic sclk_reg;
  logic done_reg;
  logic roll;

  assign roll = port.tx_tick && (div_reg == `NBU_DIV_LAST);
  assign last_idx = (port.mode == NBU_SHIFT) ? `NBU_LAST_SH :
    ((port.mode == NBU_UART8) ? `NBU_LAST_8B : `NBU_LAST_9B);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 4'h0;
    else if (port.tx_tick)
      div_reg <= div_reg + 4'h1;
  end

  // Bit times follow the free-running divider, not the buffer write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_reg <= 1'h0;
      busy_reg <= 1'h0;
      frame_reg <= 11'h7FF;
      cnt_reg <= 4'h0;
      txd_reg <= 1'h1;
      done_reg <= 1'h0;
    end
    else
    begin
      done_reg <= 1'h0;
      if (port.tx_load && !pend_reg && !busy_reg)
      begin
        pend_reg <= 1'h1;
        if (port.mode == NBU_SHIFT)
          frame_reg <= {3'h7, port.tx_word[7:0]};
        else if (port.mode == NBU_UART8)
          frame_reg <= {2'h3, port.tx_word[7:0], 1'h0};
        else
          frame_reg <= {1'h1, port.tx_word, 1'h0}; // see (R8) see (R11)
      end
      else if (roll && pend_reg)
      begin
        pend_reg <= 1'h0; // see (R14)
        busy_reg <= 1'h1;
        cnt_reg <= 4'h0;
        txd_reg <= frame_reg[0]; // see (R15)
        frame_reg <= {1'h1, frame_reg[10:1]};
      end
      else if (roll && busy_reg)
      begin
        txd_reg <= frame_reg[0];
        frame_reg <= {1'h1, frame_reg[10:1]};
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg + 4'h1 == last_idx)
        begin
          busy_reg <= 1'h0; // see (R15)
          done_reg <= 1'h1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sclk_reg <= 1'h1;
    else if (busy_reg && port.mode == NBU_SHIFT && !div_reg[`NBU_DIV_HALF])
      sclk_reg <= port.mp;
    else
      sclk_reg <= !port.mp; // see (R6)
  end

  assign port.txd = txd_reg;
  assign port.sclk = sclk_reg;
  assign port.tx_busy = busy_reg;
  assign port.tx_pend = pend_reg;
  assign port.tx_roll = roll;
  assign port.tx_done_set = done_reg;
endmodule : nbu_uart_tx

// *** nbu_uart_rx.sv ***
`timescale 1ns/100ps
`include "nbu_uart_regs.svh"
module nbu_uart_rx
  import nbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  nbu_port_if.rx port
);
  nbu_rx_state_t state_reg;
  logic [3:0] div_reg;
  logic [1:0] smp_reg;
  logic prev_reg;
  logic [9:0] shift_reg;
  logic load_reg;
  logic ninth_reg;
  logic fe_reg;
  logic [7:0] data_reg;
  logic maj;
  logic [9:0] shift_next;
  logic at_pt;
  logic edge_seen;

  assign maj = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & port.rx_line) |
    (smp_reg[1] & port.rx_line); // see (R17)
  assign shift_next = {maj, shift_reg[9:1]};
  assign at_pt = port.rx_tick && (div_reg == `NBU_SMP_C);
  assign edge_seen = port.rx_tick && prev_reg && !port.rx_line;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 4'h0;
    else if (state_reg == NBU_RX_IDLE && edge_seen)
      div_reg <= 4'h0; // see (R16)
    else if (port.rx_tick)
      div_reg <= div_reg + 4'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      smp_reg <= 2'h3;
    else if (port.rx_tick && div_reg == `NBU_SMP_A)
      smp_reg[0] <= port.rx_line;
    else if (port.rx_tick && div_reg == `NBU_SMP_B)
      smp_reg[1] <= port.rx_line;
  end

  // Leaving a frame clears prev_reg so a low stop level cannot retrigger
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= NBU_RX_IDLE;
      prev_reg <= 1'h0;
      shift_reg <= `NBU_RX_ONES;
      load_reg <= 1'h0;
      fe_reg <= 1'h0;
      ninth_reg <= 1'h0;
      data_reg <= 8'h00;
    end
    else
    begin
      load_reg <= 1'h0;
      fe_reg <= 1'h0;
      case (state_reg)
        NBU_RX_IDLE:
        begin
          if (port.rx_tick)
            prev_reg <= port.rx_line;
          if (port.rx_enable && port.mode != NBU_SHIFT && edge_seen) // see (R7)
          begin
            shift_reg <= `NBU_RX_ONES; // see (R16)
            state_reg <= NBU_RX_DATA;
          end
        end
        NBU_RX_DATA:
        begin
          if (!port.rx_enable)
          begin
            state_reg <= NBU_RX_IDLE; // see (R7)
            prev_reg <= 1'h0;
          end
          else if (at_pt && shift_reg == `NBU_RX_ONES && maj)
          begin
            state_reg <= NBU_RX_IDLE; // see (R18)
            prev_reg <= 1'h0;
          end
          else if (at_pt)
          begin
            shift_reg <= shift_next;
            if (!shift_next[0]) // see (R19)
            begin
              if (!port.rx_flag && (!port.mp || shift_next[9])) // see (R5) see (R4)
              begin
                load_reg <= 1'h1;
                data_reg <= shift_next[8:1]; // see (R20)
                ninth_reg <= shift_next[9]; // see (R10)
              end
              if (port.mode == NBU_UART8)
              begin
                fe_reg <= !shift_next[9]; // see (R1)
                state_reg <= NBU_RX_IDLE;
                prev_reg <= 1'h0;
              end
              else
                state_reg <= NBU_RX_STOP; // see (R21)
            end
          end
        end
        NBU_RX_STOP:
        begin
          if (!port.rx_enable || at_pt)
          begin
            fe_reg <= port.rx_enable && at_pt && !maj; // see (R1)
            state_reg <= NBU_RX_IDLE; // see (R20)
            prev_reg <= 1'h0;
          end
        end
        default:
          state_reg <= NBU_RX_IDLE;
      endcase
    end
  end

  assign port.rx_load = load_reg;
  assign port.rx_data = data_reg;
  assign port.rx_ninth = ninth_reg;
  assign port.fe_set = fe_reg;
endmodule : nbu_uart_rx

// *** nbu_uart.sv ***
// What this block does
// (R1) Invalid stop bit sets the framing error flag; only software clears it.
// (R2) Control bit 7 shows framing error or mode bit, by the field select bit.
// (R3) Two mode bits pick shift register, 8-bit, fixed 9-bit or timed 9-bit.
// (R4) 8-bit mode with filtering: receive flag only on a valid stop bit.
// (R5) Final shift loads only if receive flag clear and filter passes.
// (R6) Shift register mode: shift clock idles at the inverse of filter bit.
// (R7) Frames are accepted only while receive enable is set.
// (R8) 9-bit modes send the programmed ninth transmit bit.
// (R9) Shift register mode: ninth transmit bit selects Timer 1 as clock.
// (R10) Ninth receive bit holds ninth bit, or stop bit in 8-bit mode.
// (R11) 9-bit frame: start zero, 8 data LSB first, ninth, stop one.
// (R12) Fixed 9-bit mode runs at osc/16 or osc/32 by baud double bit.
// (R13) Timed 9-bit mode takes baud from Timer 1 or Timer 2 per direction.
// (R14) Buffer write loads ninth bit; sending starts after next rollover.
// (R15) Start bit, data, stop; done flag set at the last rollover.
// (R16) Receive line sampled at 16x; falling edge resets divider, presets ones.
// (R17) Each bit is the majority of samples at states 7, 8 and 9.
// (R18) A start bit not read as zero sends the receiver back to edge search.
// (R19) Ten-bit shift register; start at far end triggers the final load.
// (R20) Accepted frame fills buffer and ninth bit; edge search resumes after.
// (R21) In 9-bit modes the stop bit value never touches buffer, RI or RB8; a low one sets the framing error flag.
// (R22) Done flags stay set until cleared and drive the interrupt request.
`timescale 1ns/100ps
`include "nbu_uart_regs.svh"
module nbu_uart
  import nbu_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`NBU_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic timer1_ovf,
  input wire logic timer2_ovf,
  output logic txd,
  output logic shift_clk,
  output logic serial_irq
);
  nbu_port_if port ();

  nbu_mode_t mode;
  logic mode_hi_reg;
  logic mode_lo_reg;
  logic mp_reg;
  logic ren_reg;
  logic tb8_reg;
  logic rb8_reg;
  logic ti_reg;
  logic ri_reg;
  logic fe_reg;
  logic [7:0] rbuf_reg;
  logic [3:0] cfg_reg;
  logic half_reg;
  logic rxd_meta_reg;
  logic rxd_sync_reg;
  logic irq_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic setup;
  logic access;
  logic wr_ctrl;
  logic wr_buf;
  logic wr_cfg;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [7:0] ctrl_view;
  logic fixed_tick;
  logic fsel;

  assign fsel = cfg_reg[`NBU_C_FSEL];
  assign mode = nbu_mode_t'({mode_hi_reg, mode_lo_reg}); // see (R3)
  assign setup = psel && !penable;
  assign access = psel && penable && pready_reg;
  assign wr_ctrl = access && pwrite && (paddr == `NBU_CTRL_OFS);
  assign wr_buf = access && pwrite && (paddr == `NBU_BUF_OFS);
  assign wr_cfg = access && pwrite && (paddr == `NBU_CFG_OFS);
  assign ctrl_view = {fsel ? fe_reg : mode_hi_reg, mode_lo_reg, mp_reg, ren_reg,
    tb8_reg, rb8_reg, ti_reg, ri_reg}; // see (R2)

  always_comb
  begin
    rd_mux = 32'h0;
    rd_hit = 1'h1;
    case (paddr)
      `NBU_CTRL_OFS: rd_mux = {24'h0, ctrl_view};
      `NBU_BUF_OFS: rd_mux = {24'h0, rbuf_reg};
      `NBU_CFG_OFS: rd_mux = {28'h0, cfg_reg};
      default: rd_hit = 1'h0;
    endcase
  end

  // Zero wait states: read data is captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg <= 32'h0;
      pslverr_reg <= 1'h0;
    end
    else if (setup)
    begin
      prdata_reg <= pwrite ? 32'h0 : rd_mux;
      pslverr_reg <= !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready_reg <= 1'h0;
    else
      pready_reg <= 1'h1;
  end

  // The receive pin is asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rxd_meta_reg <= 1'h1;
      rxd_sync_reg <= 1'h1;
    end
    else
    begin
      rxd_meta_reg <= rxd;
      rxd_sync_reg <= rxd_meta_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_hi_reg <= 1'h0;
      mode_lo_reg <= 1'h0;
      mp_reg <= 1'h0;
      ren_reg <= 1'h0;
      tb8_reg <= 1'h0;
    end
    else if (wr_ctrl)
    begin
      if (!fsel)
        mode_hi_reg <= pwdata[`NBU_B_TOP]; // see (R2)
      mode_lo_reg <= pwdata[`NBU_B_MLO];
      mp_reg <= pwdata[`NBU_B_MP];
      ren_reg <= pwdata[`NBU_B_REN]; // see (R7)
      tb8_reg <= pwdata[`NBU_B_TB8];
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fe_reg <= 1'h0;
    else
      fe_reg <= port.fe_set | ((wr_ctrl && fsel) ? pwdata[`NBU_B_TOP] : fe_reg); // see (R1)
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ti_reg <= 1'h0;
      ri_reg <= 1'h0;
    end
    else
    begin
      ti_reg <= port.tx_done_set | (wr_ctrl ? pwdata[`NBU_B_TI] : ti_reg); // see (R22)
      ri_reg <= port.rx_load | (wr_ctrl ? pwdata[`NBU_B_RI] : ri_reg); // see (R22)
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rb8_reg <= 1'h0;
      rbuf_reg <= 8'h00;
    end
    else if (port.rx_load)
    begin
      rb8_reg <= port.rx_ninth; // see (R10)
      rbuf_reg <= port.rx_data; // see (R20)
    end
    else if (wr_ctrl)
      rb8_reg <= pwdata[`NBU_B_RB8];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cfg_reg <= `NBU_CFG_RST;
    else if (wr_cfg)
      cfg_reg <= pwdata[3:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      half_reg <= 1'h0;
    else
      half_reg <= !half_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'h0;
    else
      irq_reg <= ti_reg | ri_reg; // see (R22)
  end

  // 16x ticks: every cycle gives osc/16 baud, every other cycle osc/32
  assign fixed_tick = cfg_reg[`NBU_C_BDBL] ? 1'h1 : half_reg; // see (R12)

  always_comb
  begin
    case (mode)
      NBU_SHIFT:
      begin
        port.tx_tick = tb8_reg ? timer1_ovf : 1'h1; // see (R9)
        port.rx_tick = 1'h0;
      end
      NBU_UART9F:
      begin
        port.tx_tick = fixed_tick;
        port.rx_tick = fixed_tick;
      end
      default:
      begin
        port.tx_tick = cfg_reg[`NBU_C_TXT2] ? timer2_ovf : timer1_ovf; // see (R13)
        port.rx_tick = cfg_reg[`NBU_C_RXT2] ? timer2_ovf : timer1_ovf; // see (R13)
      end
    endcase
  end

  assign port.mode = mode;
  assign port.tx_load = wr_buf; // see (R14)
  assign port.tx_word = {tb8_reg, pwdata[7:0]}; // see (R14)
  assign port.rx_enable = ren_reg;
  assign port.mp = mp_reg;
  assign port.rx_flag = ri_reg;
  assign port.rx_line = rxd_sync_reg;

  nbu_uart_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .port(port)
  );

  nbu_uart_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .port(port)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd = port.txd;
  assign shift_clk = port.sclk;
  assign serial_irq = irq_reg;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_fe_sticky;
    fe_reg && !(wr_ctrl && fsel) |=> fe_reg;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("frame error lost"); // see (R1)

  property p_fe_set;
    port.fe_set |=> fe_reg;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("frame error not set"); // see (R1)

  property p_top_bit;
    setup && !pwrite && paddr == `NBU_CTRL_OFS
      |=> prdata_reg[`NBU_B_TOP] == ($past(fsel) ? $past(fe_reg) : $past(mode_hi_reg));
  endproperty
  a_top_bit: assert property (p_top_bit) else $error("bit 7 view wrong"); // see (R2)

  property p_half_rate;
    (mode == NBU_UART9F && !cfg_reg[`NBU_C_BDBL])[*2] |-> port.tx_tick != $past(port.tx_tick);
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("osc/32 tick wrong"); // see (R12)

  property p_full_rate;
    mode == NBU_UART9F && cfg_reg[`NBU_C_BDBL] |-> port.tx_tick && port.rx_tick;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("osc/16 tick wrong"); // see (R12)

  property p_timed_rate;
    mode == NBU_UART9V |-> port.rx_tick == (cfg_reg[`NBU_C_RXT2] ? timer2_ovf : timer1_ovf);
  endproperty
  a_timed_rate: assert property (p_timed_rate) else $error("rx timer wrong"); // see (R13)

  property p_shift_src;
    mode == NBU_SHIFT && tb8_reg |-> port.tx_tick == timer1_ovf;
  endproperty
  a_shift_src: assert property (p_shift_src) else $error("shift clock source"); // see (R9)

  property p_rx_gate;
    port.rx_load |-> !$past(ri_reg) && (!$past(mp_reg) || port.rx_ninth);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("load not gated"); // see (R5) see (R4)

  property p_rx_store;
    port.rx_load |=> ri_reg && rbuf_reg == $past(port.rx_data) && rb8_reg == $past(port.rx_ninth);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("frame not stored"); // see (R20)

  property p_rx_off;
    !ren_reg |=> !port.rx_load;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("load while disabled"); // see (R7)

  property p_sclk_idle;
    mode == NBU_SHIFT && !port.tx_busy |=> shift_clk == !$past(mp_reg);
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("idle clock level"); // see (R6)

  sequence s_tx_wait;
    port.tx_pend && !port.tx_roll;
  endsequence

  sequence s_tx_go;
    port.tx_pend && port.tx_roll && mode != NBU_SHIFT;
  endsequence

  property p_tx_wait;
    s_tx_wait |=> !port.tx_busy && txd;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("sent before rollover"); // see (R14)

  property p_tx_start;
    s_tx_go |=> port.tx_busy && !txd;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("no start bit"); // see (R15)

  property p_ti_set;
    port.tx_done_set |=> ti_reg ##1 serial_irq;
  endproperty
  a_ti_set: assert property (p_ti_set) else $error("done flag or irq"); // see (R22)

  property p_irq;
    !ti_reg && !ri_reg |=> !serial_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("spurious irq"); // see (R22)
endmodule : nbu_uart

// *** nbu_uart_peer.sv ***
`timescale 1ns/100ps
module nbu_uart_peer (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  int bit_cyc = 16;
  int got_cnt = 0;
  logic [8:0] got_word;
  logic got_stop;
  initial rxd = 1'b1;
  // Idle high between frames; one spare idle bit keeps frames apart
  task automatic send(input logic [8:0] w, input logic stop);
    logic [10:0] f;
    f = {stop, w, 1'b0};
    @(posedge pclk);
    for (int i = 0; i < 11; i++)
    begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge pclk);
    end
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge pclk);
  endtask : send
  task automatic pulse(input int n);
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (n) @(posedge pclk);
    rxd <= 1'b1;
    repeat (3 * bit_cyc) @(posedge pclk);
  endtask : pulse
  // Samples mid-bit, so a drift of under half a bit is tolerated
  always
  begin
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge pclk);
    for (int i = 0; i < 10; i++)
    begin
      repeat (bit_cyc) @(posedge pclk);
      if (i < 9)
        got_word[i] = txd;
      else
        got_stop = txd;
    end
    got_cnt++;
  end
endmodule : nbu_uart_peer

// *** nbu_uart_tb_top.sv ***
`timescale 1ns/100ps
`include "nbu_uart_regs.svh"
module nbu_uart_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [`NBU_ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, shift_clk, serial_irq;
  int error_cnt = 0;
  int check_count = 0;
  logic [1:0] tdiv = 2'h0;
  always #2.5 pclk = ~pclk;
  // Timer 1 overflows every 2nd cycle, timer 2 every 4th, so the sources differ
  always @(posedge pclk) tdiv <= tdiv + 2'h1;
  nbu_uart dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .timer1_ovf(tdiv[0]), .timer2_ovf(tdiv == 2'h3), .txd(txd),
    .shift_clk(shift_clk), .serial_irq(serial_irq));
  nbu_uart_peer peer (.pclk(pclk), .txd(txd), .rxd(rxd));
  task automatic test_done;
    $display("Checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string nm);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, {24'h0, x}, q);
    chk({nm, "_slverr"}, 32'h0, {31'h0, e});
  endtask : rd
  task automatic rxf(input logic [8:0] w, input logic s, input logic [7:0] c,
    input logic [7:0] b);
    peer.send(w, s);
    rd(`NBU_CTRL_OFS, c, "ctrl");
    rd(`NBU_BUF_OFS, b, "rx_buf");
  endtask : rxf
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(`NBU_CTRL_OFS, 8'h00, "ctrl_rst");
    rd(`NBU_CFG_OFS, 8'h00, "cfg_rst");
    rd(`NBU_BUF_OFS, 8'h00, "buf_rst");
    apb(1'b0, 8'h04, 32'h0, q, e);
    chk("unmapped_rd", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'b1, 8'h04, 32'hFF, q, e);
    chk("unmapped_wr", 32'h1, {31'h0, e});
  endtask : t_regs
  // Done flag must land at the last of the eleven rollovers after the write
  task automatic t_tx(input logic [7:0] cfg, input logic [7:0] c, input int bc);
    int n = 0;
    int c0;
    wr(`NBU_CFG_OFS, cfg);
    wr(`NBU_CTRL_OFS, c);
    peer.bit_cyc = bc;
    c0 = peer.got_cnt;
    wr(`NBU_BUF_OFS, 8'hA5);
    while (serial_irq !== 1'b1 && n < 12 * bc)
    begin
      @(posedge pclk);
      n++;
    end
    chk("tx_done_time", 32'h1, {31'h0, n >= 10 * bc && n <= 11 * bc + 8});
    repeat (bc) @(posedge pclk);
    chk("tx_frames", c0 + 1, peer.got_cnt);
    chk("tx_word", 32'h1A5, {23'h0, peer.got_word});
    chk("tx_stop", 32'h1, {31'h0, peer.got_stop});
    rd(`NBU_CTRL_OFS, c | 8'h02, "ctrl_ti");
    wr(`NBU_CTRL_OFS, c);
    repeat (3) @(posedge pclk);
    chk("irq_clr", 32'h0, {31'h0, serial_irq});
  endtask : t_tx
  // Shift register mode: data bits are taken at each rising shift clock
  task automatic t_sh(input logic [7:0] c, input int bc);
    int n = 0;
    int r = 0;
    logic [7:0] g = 8'h00;
    logic s = 1'b1;
    wr(`NBU_CTRL_OFS, c);
    wr(`NBU_BUF_OFS, 8'h5A);
    while (serial_irq !== 1'b1 && n < 10 * bc)
    begin
      @(posedge pclk);
      n++;
      if (shift_clk && !s)
      begin
        r++;
        g = {txd, g[7:1]};
      end
      s = shift_clk;
    end
    chk("sh_time", 32'h1, {31'h0, n >= 8 * bc && n <= 9 * bc + 8});
    chk("sh_edges", 32'h8, r);
    chk("sh_data", 32'h5A, {24'h0, g});
    wr(`NBU_CTRL_OFS, c);
  endtask : t_sh
  // 8-bit mode: the stop bit lands in the ninth receive bit
  task automatic t_m1;
    wr(`NBU_CFG_OFS, 8'h00);
    wr(`NBU_CTRL_OFS, 8'h50);
    peer.bit_cyc = 32;
    rxf(9'h0A5, 1'b1, 8'h51, 8'hA5);
    wr(`NBU_CTRL_OFS, 8'h70);
    rxf(9'h03C, 1'b1, 8'h70, 8'hA5);
    rxf(9'h1C3, 1'b1, 8'h75, 8'hC3);
    wr(`NBU_CFG_OFS, 8'h08);
    wr(`NBU_CTRL_OFS, 8'h50);
    peer.bit_cyc = 64;
    rxf(9'h15A, 1'b1, 8'h55, 8'h5A);
    wr(`NBU_CFG_OFS, 8'h09);
    rd(`NBU_CTRL_OFS, 8'hD5, "ctrl_fe_m1");
  endtask : t_m1
  task automatic t_rx;
    wr(`NBU_CFG_OFS, 8'h02);
    wr(`NBU_CTRL_OFS, 8'h90);
    peer.bit_cyc = 16;
    rxf(9'h13C, 1'b1, 8'h95, 8'h3C);
    rxf(9'h055, 1'b1, 8'h95, 8'h3C);
    wr(`NBU_CTRL_OFS, 8'hB0);
    rxf(9'h0AA, 1'b1, 8'hB0, 8'h3C);
    rxf(9'h1C3, 1'b1, 8'hB5, 8'hC3);
  endtask : t_rx
  task automatic t_off_glitch;
    wr(`NBU_CTRL_OFS, 8'h80);
    rxf(9'h011, 1'b1, 8'h80, 8'hC3);
    wr(`NBU_CTRL_OFS, 8'h90);
    peer.pulse(4);
    rd(`NBU_CTRL_OFS, 8'h90, "ctrl_glitch");
    rxf(9'h066, 1'b1, 8'h91, 8'h66);
  endtask : t_off_glitch
  task automatic t_ferr;
    wr(`NBU_CFG_OFS, 8'h03);
    wr(`NBU_CTRL_OFS, 8'h10);
    rxf(9'h0F0, 1'b0, 8'h91, 8'hF0);
    wr(`NBU_CTRL_OFS, 8'h90);
    rxf(9'h0F1, 1'b1, 8'h91, 8'hF1);
    wr(`NBU_CTRL_OFS, 8'h10);
    rd(`NBU_CTRL_OFS, 8'h10, "ctrl_fe_clr");
    wr(`NBU_CFG_OFS, 8'h02);
    rd(`NBU_CTRL_OFS, 8'h90, "ctrl_mode_view");
  endtask : t_ferr
  task automatic t_shift;
    wr(`NBU_CTRL_OFS, 8'h00);
    repeat (4) @(posedge pclk);
    chk("sclk_idle_hi", 32'h1, {31'h0, shift_clk});
    wr(`NBU_CTRL_OFS, 8'h20);
    repeat (4) @(posedge pclk);
    chk("sclk_idle_lo", 32'h0, {31'h0, shift_clk});
    rd(`NBU_CTRL_OFS, 8'h20, "ctrl_shift");
  endtask : t_shift
  initial
  begin
    repeat (40000) @(posedge pclk);
    error_cnt++;
    test_done;
  end
  initial
  begin
    repeat (7) @(posedge pclk);
    chk("rst_txd", 32'h1, {31'h0, txd});
    chk("rst_sclk", 32'h1, {31'h0, shift_clk});
    chk("rst_irq", 32'h0, {31'h0, serial_irq});
    chk("rst_pready", 32'h0, {31'h0, pready});
    @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_tx(8'h02, 8'h88, 16);
    t_tx(8'h00, 8'h88, 32);
    t_tx(8'h00, 8'hC8, 32);
    t_tx(8'h04, 8'hC8, 64);
    t_rx;
    t_off_glitch;
    t_ferr;
    t_m1;
    t_shift;
    t_sh(8'h00, 16);
    t_sh(8'h08, 32);
    test_done;
  end
endmodule : nbu_uart_tb_top
